// >>> runaway_watchdog_timer.sv
/*
 * Runaway watchdog timer: mode and command registers on Wishbone,
 * binary counter with four taps, watchdog output pin, interrupt
 * pulse and optional internal chip reset request.
 * Assumes idle and stop mode flags come from same-clock logic and
 * that the chip reset request is fed back into rst_n by the system.
 */
`timescale 1ns/1ps
module runaway_watchdog_timer
   import wdt_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Wishbone slave
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   input  wire logic        wbWe,
   input  wire logic [3:0]  wbAdr,
   input  wire logic [3:0]  wbSel,
   input  wire logic [31:0] wbDatI,
   output logic             wbAck,
   output logic [31:0]      wbDatO,
   // Power modes
   input  wire logic        idleMode,
   input  wire logic        stopMode,
   // Watchdog outputs
   output logic             watchdog_out_pin,
   output logic             watchdog_interrupt,
   output logic             chipResetReq
);

   // ***********************************************************
   // Declarations
   // ***********************************************************
   logic             enable_q;
   logic             enable_d;
   logic [1:0]       period_q;
   logic [1:0]       period_d;
   logic             resCon_q;
   logic             resCon_d;
   logic             disabled_q;
   logic             disabled_d;
   wdtState_t        state_q;
   wdtState_t        state_d;
   logic [PULSE_W-1:0] pulseCnt_q;
   logic [PULSE_W-1:0] pulseCnt_d;
   logic             pin_q;
   logic             pin_d;
   logic             irq_q;
   logic             irq_d;
   logic             rstReq_q;
   logic             rstReq_d;
   logic             ovfSeen_q;
   logic             ovfSeen_d;

   logic             modeWr;
   logic             cmdWr;
   logic             clearCmd;
   logic             disableCmd;
   logic             cntClear;
   logic             cntRun;
   logic             overflow;
   logic [CNT_W-1:0] count;
   logic [31:0]      modeWord;
   logic [31:0]      statWord;
   logic [31:0]      cntWord;
   logic             pulseDone;

   // ***********************************************************
   // Bus front end
   // ***********************************************************
   wdt_bus_slave u_bus (
      .clock    (clock),
      .rst_n    (rst_n),
      .wbCyc    (wbCyc),
      .wbStb    (wbStb),
      .wbWe     (wbWe),
      .wbAdr    (wbAdr),
      .wbSel    (wbSel),
      .wbAck    (wbAck),
      .wbDatO   (wbDatO),
      .modeWord (modeWord),
      .statWord (statWord),
      .cntWord  (cntWord),
      .modeWr   (modeWr),
      .cmdWr    (cmdWr)
   );

   // ***********************************************************
   // Register read words
   // ***********************************************************
   // Unused bits read as zero
   always_comb begin
      modeWord                 = '0;
      modeWord[EN_BIT]         = enable_q;
      modeWord[PER_LSB+1 -: 2] = period_q;
      modeWord[RESCON_BIT]     = resCon_q;
      statWord                 = '0;
      statWord[ST_PIN_BIT]     = pin_q;
      statWord[ST_OVF_BIT]     = ovfSeen_q;
      statWord[ST_DIS_BIT]     = disabled_q;
      statWord[ST_PULSE_BIT]   = rstReq_q;
      cntWord                  = {9'h000, count};
   end

   // ***********************************************************
   // Command decode
   // ***********************************************************
   always_comb begin
      // Any other command value decodes to nothing
      clearCmd   = cmdWr && (wbDatI[7:0] == CLEAR_CODE);
      disableCmd = cmdWr && (wbDatI[7:0] == DISABLE_CODE);
   end

   // ***********************************************************
   // Mode register
   // ***********************************************************
   // Only byte lane zero carries mode bits
   always_comb begin
      enable_d = enable_q;
      period_d = period_q;
      resCon_d = resCon_q;
      if (modeWr) begin
         enable_d = wbDatI[EN_BIT];
         period_d = wbDatI[PER_LSB+1 -: 2];
         resCon_d = wbDatI[RESCON_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         enable_q <= EN_RST;
         period_q <= PER_RST;
         resCon_q <= RESCON_RST;
      end else begin
         enable_q <= enable_d;
         period_q <= period_d;
         resCon_q <= resCon_d;
      end
   end

   // ***********************************************************
   // Disable state
   // ***********************************************************
   // Two-step disable guards against a runaway write
   // Enable write wins, since both cannot share one write
   always_comb begin
      disabled_d = disabled_q;
      if (modeWr && wbDatI[EN_BIT]) begin
         disabled_d = 1'b0;
      end else if (disableCmd && !enable_q) begin
         disabled_d = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         disabled_q <= 1'b0;
      end else begin
         disabled_q <= disabled_d;
      end
   end

   // ***********************************************************
   // Counter
   // ***********************************************************
   always_comb begin
      pulseDone = (state_q == ST_PULSE) &&
                  (pulseCnt_q == PULSE_W'(PULSE_CYC - 1));
      cntClear  = clearCmd || pulseDone;
      // Bus release is not a stop condition
      cntRun    = !disabled_q && !idleMode && !stopMode &&
                  (state_q != ST_PULSE);
   end

   wdt_tap_counter u_cnt (
      .clock     (clock),
      .rst_n     (rst_n),
      .clear     (cntClear),
      .run       (cntRun),
      .periodSel (period_q),
      .count     (count),
      .overflow  (overflow)
   );

   // ***********************************************************
   // Output pin, interrupt and reset pulse
   // ***********************************************************
   // Interrupt and reset request are one-shot defaults
   // Pin and overflow flag hold unless a state changes them
   always_comb begin
      state_d    = state_q;
      pulseCnt_d = pulseCnt_q;
      pin_d      = pin_q;
      irq_d      = 1'b0;
      rstReq_d   = 1'b0;
      ovfSeen_d  = ovfSeen_q;
      case (state_q)
         ST_RUN: begin
            if (overflow) begin
               irq_d     = 1'b1;
               pin_d     = 1'b0;
               ovfSeen_d = 1'b1;
               if (resCon_q) begin
                  state_d    = ST_PULSE;
                  pulseCnt_d = '0;
                  rstReq_d   = 1'b1;
               end else begin
                  state_d = ST_LOW;
               end
            end
         end
         // Pin held low, counter still running
         ST_LOW: begin
            if (clearCmd) begin
               pin_d     = 1'b1;
               ovfSeen_d = 1'b0;
               state_d   = ST_RUN;
            end else if (overflow) begin
               // Repeat overflow pulses the interrupt again
               irq_d = 1'b1;
               if (resCon_q) begin
                  state_d    = ST_PULSE;
                  pulseCnt_d = '0;
                  rstReq_d   = 1'b1;
               end
            end
         end
         // Counter frozen; its clear at the end releases the pin
         ST_PULSE: begin
            if (pulseDone) begin
               pin_d     = 1'b1;
               ovfSeen_d = 1'b0;
               state_d   = ST_RUN;
            end else begin
               pulseCnt_d = pulseCnt_q + PULSE_W'(1);
               rstReq_d   = 1'b1;
            end
         end
         // Unused code recovers to the idle run state
         default: begin
            state_d = ST_RUN;
            pin_d   = 1'b1;
         end
      endcase
   end

   // ***********************************************************
   // Output registers
   // ***********************************************************
   // Pin resets high, so no false overflow is seen at release
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_q    <= ST_RUN;
         pulseCnt_q <= '0;
         pin_q      <= 1'b1;
         irq_q      <= 1'b0;
         rstReq_q   <= 1'b0;
         ovfSeen_q  <= 1'b0;
      end else begin
         state_q    <= state_d;
         pulseCnt_q <= pulseCnt_d;
         pin_q      <= pin_d;
         irq_q      <= irq_d;
         rstReq_q   <= rstReq_d;
         ovfSeen_q  <= ovfSeen_d;
      end
   end

   // ***********************************************************
   // Top outputs, straight from flip-flops
   // ***********************************************************
   assign watchdog_out_pin   = pin_q;
   assign watchdog_interrupt = irq_q;
   assign chipResetReq       = rstReq_q;

endmodule : runaway_watchdog_timer

// >>> wdt_pkg.sv
/*
 * Shared constants for the runaway watchdog: register offsets, field
 * positions, reset values, command codes, counter taps and timing.
 * Assumes a 125 MHz system clock used as the oscillator rate.
 */
package wdt_pkg;

   // ***********************************************************
   // Register map (byte addresses, one word each)
   // ***********************************************************
   localparam logic [3:0] MODE_OFS = 4'h0;
   localparam logic [3:0] CMD_OFS  = 4'h4;
   localparam logic [3:0] STAT_OFS = 4'h8;
   localparam logic [3:0] CNT_OFS  = 4'hC;

   // ***********************************************************
   // Mode register fields and reset values
   // ***********************************************************
   localparam int         EN_BIT     = 7;
   localparam int         PER_LSB    = 5;
   localparam int         RESCON_BIT = 1;
   localparam logic       EN_RST     = 1'b1;
   localparam logic       RESCON_RST = 1'b0;
   localparam logic [1:0] PER_RST    = 2'h0;

   // ***********************************************************
   // Status register fields
   // ***********************************************************
   localparam int ST_PIN_BIT   = 0;
   localparam int ST_OVF_BIT   = 1;
   localparam int ST_DIS_BIT   = 2;
   localparam int ST_PULSE_BIT = 3;

   // ***********************************************************
   // Command codes
   // ***********************************************************
   localparam logic [7:0] CLEAR_CODE   = 8'h4E;
   localparam logic [7:0] DISABLE_CODE = 8'hB1;

   // ***********************************************************
   // Counter: stage zero halves the clock, 22 stages follow
   // ***********************************************************
   localparam int CNT_W = 23;
   localparam logic [CNT_W-1:0] TAP16 = 23'h00FFFF;
   localparam logic [CNT_W-1:0] TAP18 = 23'h03FFFF;
   localparam logic [CNT_W-1:0] TAP20 = 23'h0FFFFF;
   localparam logic [CNT_W-1:0] TAP22 = 23'h3FFFFF;

   // ***********************************************************
   // Internal reset pulse: 8 states, one state is two clocks
   // ***********************************************************
   localparam int PULSE_STATES  = 8;
   localparam int CLK_PER_STATE = 2;
   localparam int PULSE_CYC     = PULSE_STATES * CLK_PER_STATE;
   localparam int PULSE_W       = 5;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_LOW   = 2'b01,
      ST_PULSE = 2'b10
   } wdtState_t;

endpackage : wdt_pkg

// >>> wdt_tap_counter.sv
/*
 * Watchdog binary counter with four selectable overflow taps.
 * Assumes clear and run come from logic on the same clock.
 */
`timescale 1ns/1ps
module wdt_tap_counter
   import wdt_pkg::*;
(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // Control
   input  wire logic             clear,
   input  wire logic             run,
   input  wire logic [1:0]       periodSel,
   // Result
   output logic [CNT_W-1:0]      count,
   output logic                  overflow
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] tapMax;

   always_comb begin
      case (periodSel)
         2'h0:    tapMax = TAP16;
         2'h1:    tapMax = TAP18;
         2'h2:    tapMax = TAP20;
         default: tapMax = TAP22;
      endcase
   end

   always_comb begin
      overflow = run && !clear && (cnt_q == tapMax);
      if (clear) begin
         cnt_d = '0;
      end else if (run) begin
         cnt_d = cnt_q + 23'h000001;
      end else begin
         cnt_d = cnt_q;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign count = cnt_q;

endmodule : wdt_tap_counter

// >>> wdt_bus_slave.sv
/*
 * Classic Wishbone slave front end: one-wait-state ack, write strobes
 * for the mode and command words, registered read data.
 * Assumes a single-cycle classic master that holds its request.
 */
`timescale 1ns/1ps
module wdt_bus_slave
   import wdt_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Wishbone
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   input  wire logic        wbWe,
   input  wire logic [3:0]  wbAdr,
   input  wire logic [3:0]  wbSel,
   output logic             wbAck,
   output logic [31:0]      wbDatO,
   // Register side
   input  wire logic [31:0] modeWord,
   input  wire logic [31:0] statWord,
   input  wire logic [31:0] cntWord,
   output logic             modeWr,
   output logic             cmdWr
);

   logic        ack_q;
   logic        ack_d;
   logic [31:0] dat_q;
   logic [31:0] dat_d;
   logic        req;

   always_comb begin
      req    = wbCyc && wbStb && !ack_q;
      ack_d  = req;
      modeWr = req && wbWe && wbSel[0] && (wbAdr == MODE_OFS);
      cmdWr  = req && wbWe && wbSel[0] && (wbAdr == CMD_OFS);
      dat_d  = '0;
      if (req && !wbWe) begin
         case (wbAdr)
            MODE_OFS: dat_d = modeWord;
            STAT_OFS: dat_d = statWord;
            CNT_OFS:  dat_d = cntWord;
            default:  dat_d = '0;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         dat_q <= '0;
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end

   assign wbAck  = ack_q;
   assign wbDatO = dat_q;

endmodule : wdt_bus_slave

// >>> runaway_watchdog_monitor.sv
/*
 * Checker for the runaway watchdog top: bus handshake, pin, interrupt
 * and internal reset pulse relations.
 * Assumes it is bound to runaway_watchdog_timer on one clock.
 */
`timescale 1ns/1ps
module runaway_watchdog_monitor
   import wdt_pkg::*;
(
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst_n,
   // Wishbone
   input wire logic        wbCyc,
   input wire logic        wbStb,
   input wire logic        wbWe,
   input wire logic [3:0]  wbAdr,
   input wire logic [3:0]  wbSel,
   input wire logic [31:0] wbDatI,
   input wire logic        wbAck,
   // Watchdog outputs
   input wire logic        watchdog_out_pin,
   input wire logic        watchdog_interrupt,
   input wire logic        chipResetReq
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // Clear code write taken at this edge
   logic clrWr;
   assign clrWr = wbCyc && wbStb && !wbAck && wbWe && wbAdr == CMD_OFS
                  && wbSel[0] && wbDatI[7:0] == CLEAR_CODE;

   a_ack_follows_req: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
      else $error("ack missing after request");
   a_ack_one_shot: assert property (wbAck |=> !wbAck)
      else $error("ack longer than one cycle");
   a_intr_one_cycle: assert property (watchdog_interrupt |=> !watchdog_interrupt)
      else $error("interrupt longer than one cycle");
   a_intr_pin_low: assert property (watchdog_interrupt |-> !watchdog_out_pin)
      else $error("interrupt without pin low");
   a_pin_fall_intr: assert property ($fell(watchdog_out_pin) |-> watchdog_interrupt)
      else $error("pin fell without interrupt");
   a_pin_held_low: assert property (!watchdog_out_pin && !chipResetReq && !clrWr |=> !watchdog_out_pin)
      else $error("pin rose without clear code");
   a_clear_pin_high: assert property (clrWr && !chipResetReq |=> watchdog_out_pin)
      else $error("pin not high after clear code");
   a_pulse_sixteen: assert property ($rose(chipResetReq) |-> ##15 chipResetReq ##1 !chipResetReq)
      else $error("reset pulse length wrong");
   a_rescon_pin_low: assert property (chipResetReq |-> !watchdog_out_pin)
      else $error("pin high during reset pulse");
endmodule : runaway_watchdog_monitor

bind runaway_watchdog_timer runaway_watchdog_monitor runaway_watchdog_monitor_i (
   .clock(clock), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
   .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbAck(wbAck),
   .watchdog_out_pin(watchdog_out_pin),
   .watchdog_interrupt(watchdog_interrupt), .chipResetReq(chipResetReq));

// >>> tb_top.sv
/*
 * Self-checking bench for the runaway watchdog over classic Wishbone.
 * Assumes the checker is bound by its own file.
 */
`timescale 1ns/1ps
module tb_top;
   import wdt_pkg::*;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        wbCyc = 1'b0;
   logic        wbStb = 1'b0;
   logic        wbWe = 1'b0;
   logic [3:0]  wbAdr = 4'h0;
   logic [3:0]  wbSel = 4'h0;
   logic [31:0] wbDatI = 32'h0;
   logic        idleMode = 1'b0;
   logic        stopMode = 1'b0;
   logic        wbAck, watchdog_out_pin, watchdog_interrupt, chipResetReq;
   logic [31:0] wbDatO, d, c0, c1;
   logic [31:0] seed = 32'h8085;
   logic [7:0]  v;
   int          n_fail = 0;
   int          cmp_count = 0;
   int          n;

   always #4 clock = ~clock;

   runaway_watchdog_timer runaway_watchdog_timer_i (
      .clock(clock), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb),
      .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI),
      .wbAck(wbAck), .wbDatO(wbDatO), .idleMode(idleMode),
      .stopMode(stopMode), .watchdog_out_pin(watchdog_out_pin),
      .watchdog_interrupt(watchdog_interrupt),
      .chipResetReq(chipResetReq));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   function automatic logic [31:0] modeW(input logic en,
                                         input logic [1:0] per,
                                         input logic rc);
      logic [31:0] w;
      w = 32'h0;
      w[EN_BIT] = en;
      w[PER_LSB+:2] = per;
      w[RESCON_BIT] = rc;
      return w;
   endfunction : modeW

   task automatic cmp(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
         n_fail++;
      end
   endtask : cmp

   task automatic test_done;
      $display("compares %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   // ***********************************************************
   // Wishbone classic single cycle
   // ***********************************************************
   task automatic bus(input logic we, input logic [3:0] adr,
                      input logic [3:0] sel, input logic [31:0] dat,
                      output logic [31:0] rdat);
      int i;
      @(posedge clock);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbSel <= sel;
      wbDatI <= dat;
      for (i = 0; i < 20; i++) begin
         @(posedge clock);
         if (wbAck === 1'b1) break;
      end
      rdat = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
      if (i == 20) begin
         $display("wrong value bus ack: expected 1, seen 0");
         n_fail++;
         test_done();
      end
   endtask : bus

   task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
      logic [31:0] junk;
      bus(1'b1, adr, 4'hF, dat, junk);
   endtask : wr

   task automatic rd(input logic [3:0] adr, output logic [31:0] dat);
      bus(1'b0, adr, 4'hF, 32'h0, dat);
   endtask : rd

   // ***********************************************************
   // Main sequence
   // ***********************************************************
   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      rd(MODE_OFS, d);
      cmp("mode reset", modeW(1'b1, 2'h0, 1'b0), d);
      rd(4'h2, d);
      cmp("unmapped", 32'h0, d);
      rd(CMD_OFS, c0);
      rd(CNT_OFS, c0);
      rd(CNT_OFS, c1);
      cmp("counting", 32'h1, {31'h0, c1 > c0});
      $display("test reset done");
      for (n = 0; n < 2; n++) begin
         @(posedge clock);
         idleMode <= (n == 0);
         stopMode <= (n == 1);
         rd(CNT_OFS, c0);
         repeat (5) @(posedge clock);
         rd(CNT_OFS, c1);
         cmp("halted count", c0, c1);
      end
      idleMode <= 1'b0;
      stopMode <= 1'b0;
      $display("test halt done");
      for (n = 0; n < 20; n++) begin
         seed = xs(seed);
         v = seed[7:0];
         if (v == CLEAR_CODE || v == DISABLE_CODE) v = v ^ 8'h01;
         rd(CNT_OFS, c0);
         wr(CMD_OFS, {24'h0, v});
         rd(CNT_OFS, c1);
         cmp("not cleared", 32'h1, {31'h0, c1 > c0});
      end
      bus(1'b1, MODE_OFS, 4'hE, 32'h0, d);
      rd(MODE_OFS, d);
      cmp("mode kept", modeW(1'b1, 2'h0, 1'b0), d);
      wr(CMD_OFS, {24'h0, CLEAR_CODE});
      rd(CNT_OFS, c1);
      cmp("cleared", 32'h1, {31'h0, c1 < 32'h10});
      $display("test command done");
      wr(CMD_OFS, {24'h0, DISABLE_CODE});
      rd(STAT_OFS, d);
      cmp("enabled disable", 32'h0, {31'h0, d[ST_DIS_BIT]});
      wr(MODE_OFS, modeW(1'b0, 2'h0, 1'b0));
      rd(CNT_OFS, c0);
      rd(CNT_OFS, c1);
      cmp("count no code", 32'h1, {31'h0, c1 > c0});
      wr(CMD_OFS, {24'h0, DISABLE_CODE});
      rd(STAT_OFS, d);
      cmp("disabled", 32'h1, {31'h0, d[ST_DIS_BIT]});
      rd(CNT_OFS, c0);
      rd(CNT_OFS, c1);
      cmp("disabled count", c0, c1);
      wr(MODE_OFS, modeW(1'b1, 2'h0, 1'b0));
      rd(CNT_OFS, c0);
      rd(CNT_OFS, c1);
      cmp("reenabled", 32'h1, {31'h0, c1 > c0});
      $display("test disable done");
      for (n = 0; n < 4; n++) begin
         wr(MODE_OFS, modeW(1'b1, n[1:0], n[0]));
         rd(MODE_OFS, d);
         cmp("period", modeW(1'b1, n[1:0], n[0]), d);
      end
      wr(MODE_OFS, modeW(1'b1, 2'h0, 1'b0));
      wr(CMD_OFS, {24'h0, CLEAR_CODE});
      for (n = 0; n < 70000; n++) begin
         @(posedge clock);
         if (watchdog_interrupt === 1'b1) break;
      end
      cmp("overflow time", 32'h1,
          {31'h0, n > 65525 && n < 65545});
      @(negedge clock);
      cmp("pin low", 32'h0, {30'h0, watchdog_out_pin, chipResetReq});
      repeat (100) @(posedge clock);
      rd(STAT_OFS, d);
      cmp("pin held", 32'h0, {31'h0, d[ST_PIN_BIT]});
      wr(CMD_OFS, {24'h0, CLEAR_CODE});
      @(negedge clock);
      cmp("pin released", 32'h1, {31'h0, watchdog_out_pin});
      $display("test overflow done");
      test_done();
   end
endmodule : tb_top
